// ==== hdl/sram_pkg.sv ====
package sram_pkg;

    // ************************************************
    // link geometry
    // ************************************************
    localparam int ADDR_W         = 16;
    localparam int PAGE_BITS      = 5;
    localparam int FIFO_DEPTH_DEF = 32;
    localparam int PIN_W          = 6;

    // ************************************************
    // instruction codes
    // ************************************************
    localparam logic [7:0] CMD_READ            = 8'h03;
    localparam logic [7:0] CMD_WRITE           = 8'h02;
    localparam logic [7:0] ENTER_DUAL_LANE_CMD = 8'h3B;
    localparam logic [7:0] ENTER_QUAD_LANE_CMD = 8'h38;
    localparam logic [7:0] EXIT_MULTI_LANE_CMD = 8'hFF;
    localparam logic [7:0] MODE_REG_READ_CMD   = 8'h05;
    localparam logic [7:0] MODE_REG_WRITE_CMD  = 8'h01;

    // ************************************************
    // operating mode register
    // ************************************************
    localparam int         MODE_FIELD_HI = 7;
    localparam int         MODE_FIELD_LO = 6;
    localparam logic [7:0] MODE_RESET    = 8'h40;
    localparam logic [5:0] MODE_RSVD     = 6'h00;

    localparam logic [1:0] ACC_BYTE = 2'b00;
    localparam logic [1:0] ACC_PAGE = 2'b10;
    localparam logic [1:0] ACC_SEQ  = 2'b01;

    // ************************************************
    // lane configuration and command states
    // ************************************************
    typedef enum logic [1:0] {
        LANE_SINGLE = 2'b00,
        LANE_DUAL   = 2'b01,
        LANE_QUAD   = 2'b10
    } lane_t;

    typedef enum logic [2:0] {
        ST_CMD   = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WDATA = 3'b010,
        ST_RDATA = 3'b011,
        ST_MRWR  = 3'b100,
        ST_MRRD  = 3'b101,
        ST_DONE  = 3'b110
    } cmd_state_t;

endpackage : sram_pkg

// ==== hdl/stream_if.sv ====
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// ==== hdl/link_sampler.sv ====
`timescale 1ns/1ps
module link_sampler #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // raw pins
    input  wire logic [W-1:0] pinIn,
    // synchronised level and its previous value
    output logic      [W-1:0] syncQ,
    output logic      [W-1:0] prevQ
);

    logic [W-1:0] meta_q;

    // two flops into the clk_sys domain, third for edges
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            syncQ  <= '0;
            prevQ  <= '0;
        end else begin
            meta_q <= pinIn;
            syncQ  <= meta_q;
            prevQ  <= syncQ;
        end
    end

endmodule : link_sampler

// ==== hdl/stream_fifo.sv ====
`timescale 1ns/1ps
module stream_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // fill and drain sides
    stream_if.snk     inS,
    stream_if.src     outS
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  store [0:DEPTH-1];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic          doPush;
    logic          doPop;

    // honest full and empty from the fill count
    assign inS.ready  = (count_q != CW'(DEPTH));
    assign outS.valid = (count_q != '0);
    assign outS.data  = store[rdPtr_q];
    assign doPush     = inS.valid & inS.ready;
    assign doPop      = outS.valid & outS.ready;

    // storage write
    always_ff @(posedge clk_sys) begin
        if (doPush) begin
            store[wrPtr_q] <= inS.data;
        end
    end

    // pointers and count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doPush) begin
                wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            if (doPush && !doPop) begin
                count_q <= count_q + 1'b1;
            end else if (doPop && !doPush) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : stream_fifo

// ==== hdl/serial_sram_command_interface.sv ====
`timescale 1ns/1ps
module serial_sram_command_interface
    import sram_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // serial link pins
    input  wire logic       csN,
    input  wire logic       sck,
    input  wire logic [3:0] ioIn,
    output logic      [3:0] ioOut,
    output logic      [3:0] ioOe
);

    // ************************************************
    // helper functions
    // ************************************************

    // bits carried per serial clock
    function automatic logic [3:0] laneBits(input lane_t l);
        case (l)
            LANE_DUAL: laneBits = 4'h2;
            LANE_QUAD: laneBits = 4'h4;
            default:   laneBits = 4'h1;
        endcase
    endfunction : laneBits

    // shift received bits in below the older ones
    function automatic logic [7:0] shiftIn(input logic [7:0] s,
                                           input logic [3:0] io,
                                           input lane_t      l);
        case (l)
            LANE_DUAL: shiftIn = {s[5:0], io[1:0]};
            LANE_QUAD: shiftIn = {s[3:0], io};
            default:   shiftIn = {s[6:0], io[0]};
        endcase
    endfunction : shiftIn

    // top bits of a byte placed on the output lanes
    function automatic logic [3:0] outChunk(input logic [7:0] b,
                                            input lane_t      l);
        case (l)
            LANE_DUAL: outChunk = {2'h0, b[7:6]};
            LANE_QUAD: outChunk = b[7:4];
            default:   outChunk = {2'h0, b[7], 1'b0};
        endcase
    endfunction : outChunk

    // lanes driven while sending
    function automatic logic [3:0] oeMask(input lane_t l);
        case (l)
            LANE_DUAL: oeMask = 4'h3;
            LANE_QUAD: oeMask = 4'hF;
            default:   oeMask = 4'h2;
        endcase
    endfunction : oeMask

    // pointer advance for the active access mode
    function automatic logic [ADDR_W-1:0] nextAddr(
        input logic [ADDR_W-1:0] a,
        input logic [1:0]        acc);
        if (acc == ACC_PAGE) begin
            nextAddr = {a[ADDR_W-1:PAGE_BITS],
                        a[PAGE_BITS-1:0] + 1'b1};
        end else begin
            nextAddr = a + 1'b1;
        end
    endfunction : nextAddr

    // ************************************************
    // pin sampling
    // ************************************************
    logic [PIN_W-1:0] syncQ;
    logic [PIN_W-1:0] prevQ;

    link_sampler #(.W(PIN_W)) uSampler (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pinIn   ({csN, sck, ioIn}),
        .syncQ   (syncQ),
        .prevQ   (prevQ)
    );

    logic       csHigh;
    logic [3:0] ioSync;
    logic       sckRise;
    logic       sckFall;
    logic       armed_q;
    logic       active;

    assign csHigh  = syncQ[5];
    assign ioSync  = syncQ[3:0];
    assign sckRise = syncQ[4] & ~prevQ[4];
    assign sckFall = ~syncQ[4] & prevQ[4];
    assign active  = armed_q & ~csHigh;

    // arm only once select has been seen high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (csHigh) begin
            armed_q <= 1'b1;
        end
    end

    // ************************************************
    // state, receive path and decode
    // ************************************************
    cmd_state_t        st_q;
    lane_t             lane_q;
    logic [7:0]        mode_q;
    logic              mrWritten_q;
    logic [7:0]        rxShift_q;
    logic [3:0]        rxCnt_q;
    logic [3:0]        step;
    logic [7:0]        rxNext;
    logic              rxListen;
    logic              byteDone;
    logic              isRead_q;
    logic              addrHi_q;
    logic [7:0]        addrHiByte_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [1:0]        accMode;
    logic              txStage;
    logic              txLoad;
    logic              rdStop;
    logic [3:0]        txCnt_q;
    logic [7:0]        txShift_q;
    logic              sentOne_q;
    logic [7:0]        txByte;
    logic [7:0]        rdData_q;
    logic              fetchReq_q;
    logic              fetchGo;

    assign accMode  = mode_q[MODE_FIELD_HI:MODE_FIELD_LO];
    assign step     = laneBits(lane_q);
    assign rxNext   = shiftIn(rxShift_q, ioSync, lane_q);
    assign rxListen = (st_q == ST_CMD) || (st_q == ST_ADDR) ||
                      (st_q == ST_WDATA) || (st_q == ST_MRWR);
    assign byteDone = active && sckRise && rxListen &&
                      (rxCnt_q + step == 4'h8);

    // assemble bytes on serial clock rise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rxShift_q <= 8'h00;
            rxCnt_q   <= 4'h0;
        end else if (!active) begin
            rxCnt_q   <= 4'h0;
        end else if (sckRise && rxListen) begin
            rxShift_q <= rxNext;
            rxCnt_q   <= byteDone ? 4'h0 : rxCnt_q + step;
        end
    end

    // command state machine
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= ST_CMD;
        end else if (!active) begin
            st_q <= ST_CMD;
        end else if (byteDone) begin
            case (st_q)
                ST_CMD: begin
                    case (rxNext)
                        CMD_READ:           st_q <= ST_ADDR;
                        CMD_WRITE:          st_q <= ST_ADDR;
                        MODE_REG_READ_CMD:  st_q <= ST_MRRD;
                        MODE_REG_WRITE_CMD: st_q <= ST_MRWR;
                        default:            st_q <= ST_DONE;
                    endcase
                end
                ST_ADDR: begin
                    if (addrHi_q) begin
                        st_q <= isRead_q ? ST_RDATA : ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (accMode == ACC_BYTE) begin
                        st_q <= ST_DONE;
                    end
                end
                ST_MRWR: st_q <= ST_DONE;
                default: st_q <= st_q;
            endcase
        end else if (sckFall && rdStop) begin
            st_q <= ST_DONE;
        end
    end

    // instruction kind and address high byte
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            isRead_q     <= 1'b0;
            addrHi_q     <= 1'b0;
            addrHiByte_q <= 8'h00;
        end else if (byteDone && st_q == ST_CMD) begin
            isRead_q     <= (rxNext == CMD_READ);
            addrHi_q     <= 1'b0;
        end else if (byteDone && st_q == ST_ADDR) begin
            addrHi_q     <= 1'b1;
            addrHiByte_q <= rxNext;
        end
    end

    // lane configuration
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lane_q <= LANE_SINGLE;
        end else if (byteDone && st_q == ST_CMD) begin
            case (rxNext)
                ENTER_DUAL_LANE_CMD: lane_q <= LANE_DUAL;
                ENTER_QUAD_LANE_CMD: lane_q <= LANE_QUAD;
                EXIT_MULTI_LANE_CMD: lane_q <= LANE_SINGLE;
                default:             lane_q <= lane_q;
            endcase
        end
    end

    // operating mode register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_q      <= MODE_RESET;
            mrWritten_q <= 1'b0;
        end else if (byteDone && st_q == ST_MRWR) begin
            mode_q      <= {rxNext[7:6], MODE_RSVD};
            mrWritten_q <= 1'b1;
        end
    end

    // ************************************************
    // address pointer, write buffer and array
    // ************************************************
    logic [7:0] mem [0:(1 << ADDR_W) - 1];

    stream_if #(.W(ADDR_W + 8)) pushIf ();
    stream_if #(.W(ADDR_W + 8)) popIf ();

    stream_fifo #(.W(ADDR_W + 8), .DEPTH(FIFO_DEPTH)) uWrBuf (
        .clk_sys (clk_sys),
        .rst     (rst),
        .inS     (pushIf.snk),
        .outS    (popIf.src)
    );

    // pointer load and auto increment
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ptr_q <= '0;
        end else if (byteDone && st_q == ST_ADDR && addrHi_q) begin
            ptr_q <= {addrHiByte_q, rxNext};
        end else if (byteDone && st_q == ST_WDATA) begin
            ptr_q <= nextAddr(ptr_q, accMode);
        end else if (txLoad && st_q == ST_RDATA) begin
            ptr_q <= nextAddr(ptr_q, accMode);
        end
    end

    // write bytes wait here until the buffer takes them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pushIf.valid <= 1'b0;
            pushIf.data  <= '0;
        end else if (byteDone && st_q == ST_WDATA) begin
            pushIf.valid <= 1'b1;
            pushIf.data  <= {ptr_q, rxNext};
        end else if (pushIf.ready) begin
            pushIf.valid <= 1'b0;
        end
    end

    // reads wait for buffered writes, then own the array
    assign fetchGo     = fetchReq_q & ~popIf.valid;
    assign popIf.ready = ~fetchGo;

    // array write from the buffer
    always_ff @(posedge clk_sys) begin
        if (popIf.valid && popIf.ready) begin
            mem[popIf.data[ADDR_W+7:8]] <= popIf.data[7:0];
        end
    end

    // read fetch, also prefetches the next byte
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fetchReq_q <= 1'b0;
            rdData_q   <= 8'h00;
        end else begin
            if (fetchGo) begin
                rdData_q <= mem[ptr_q];
            end
            if ((byteDone && st_q == ST_ADDR && addrHi_q && isRead_q) ||
                (txLoad && st_q == ST_RDATA)) begin
                fetchReq_q <= 1'b1;
            end else if (fetchGo) begin
                fetchReq_q <= 1'b0;
            end
        end
    end

    // ************************************************
    // transmit path
    // ************************************************
    assign txStage = (st_q == ST_RDATA) || (st_q == ST_MRRD);
    assign rdStop  = (st_q == ST_RDATA) && (accMode == ACC_BYTE) &&
                     sentOne_q && (txCnt_q == 4'h0);
    assign txLoad  = active && sckFall && txStage && !rdStop &&
                     (txCnt_q == 4'h0);
    assign txByte  = (st_q == ST_MRRD) ? mode_q : rdData_q;

    // shift out after serial clock fall
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txShift_q <= 8'h00;
            txCnt_q   <= 4'h0;
            sentOne_q <= 1'b0;
            ioOut     <= 4'h0;
            ioOe      <= 4'h0;
        end else if (!active || st_q == ST_DONE) begin
            txCnt_q   <= 4'h0;
            sentOne_q <= 1'b0;
            ioOe      <= 4'h0;
        end else if (sckFall && txStage && !rdStop) begin
            ioOe <= oeMask(lane_q);
            if (txCnt_q == 4'h0) begin
                ioOut     <= outChunk(txByte, lane_q);
                txShift_q <= txByte << step;
                txCnt_q   <= 4'h8 - step;
                sentOne_q <= 1'b1;
            end else begin
                ioOut     <= outChunk(txShift_q, lane_q);
                txShift_q <= txShift_q << step;
                txCnt_q   <= txCnt_q - step;
            end
        end else if (sckFall && rdStop) begin
            ioOe <= 4'h0;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    a_deselect_release:
        assert property (@(posedge clk_sys) disable iff (rst)
            csHigh |=> (ioOe == 4'h0) && (st_q == ST_CMD))
        else $error("link not released while deselected");

    a_mode_default:
        assert property (@(posedge clk_sys) disable iff (rst)
            !mrWritten_q |-> (mode_q == MODE_RESET))
        else $error("mode register left its default");

    a_mode_load:
        assert property (@(posedge clk_sys) disable iff (rst)
            (byteDone && st_q == ST_MRWR)
            |=> (mode_q == {$past(rxNext[7:6]), MODE_RSVD}))
        else $error("mode register write not taken");

    a_lane_dual:
        assert property (@(posedge clk_sys) disable iff (rst)
            (byteDone && st_q == ST_CMD && rxNext == ENTER_DUAL_LANE_CMD)
            |=> (lane_q == LANE_DUAL))
        else $error("dual lane entry missed");

    a_lane_quad:
        assert property (@(posedge clk_sys) disable iff (rst)
            (byteDone && st_q == ST_CMD && rxNext == ENTER_QUAD_LANE_CMD)
            |=> (lane_q == LANE_QUAD))
        else $error("quad lane entry missed");

    a_lane_exit:
        assert property (@(posedge clk_sys) disable iff (rst)
            (byteDone && st_q == ST_CMD && rxNext == EXIT_MULTI_LANE_CMD)
            |=> (lane_q == LANE_SINGLE))
        else $error("lane exit missed");

    a_page_wrap:
        assert property (@(posedge clk_sys) disable iff (rst)
            (byteDone && st_q == ST_WDATA && accMode == ACC_PAGE)
            |=> (ptr_q[ADDR_W-1:PAGE_BITS] ==
                 $past(ptr_q[ADDR_W-1:PAGE_BITS])))
        else $error("page pointer left its page");

    a_seq_wrap:
        assert property (@(posedge clk_sys) disable iff (rst)
            (byteDone && st_q == ST_WDATA && accMode == ACC_SEQ &&
             ptr_q == 16'hFFFF) |=> (ptr_q == 16'h0000))
        else $error("sequential pointer did not roll over");

    a_byte_single:
        assert property (@(posedge clk_sys) disable iff (rst)
            (byteDone && st_q == ST_WDATA && accMode == ACC_BYTE)
            |=> (st_q == ST_DONE || st_q == ST_CMD))
        else $error("byte mode accepted a second byte");

    a_out_after_fall:
        assert property (@(posedge clk_sys) disable iff (rst)
            !$stable(ioOut) |-> $past(sckFall))
        else $error("output moved without a clock fall");

    a_fetch_ready:
        assert property (@(posedge clk_sys) disable iff (rst)
            (txLoad && st_q == ST_RDATA) |-> !fetchReq_q)
        else $error("read byte not fetched in time");

    a_unarmed_idle:
        assert property (@(posedge clk_sys) disable iff (rst)
            !armed_q |-> (st_q == ST_CMD) && (ioOe == 4'h0))
        else $error("activity before first select");

endmodule : serial_sram_command_interface

// ==== sim/spi_master_model.sv ====
`timescale 1ns/1ps
module spi_master_model (
    // clock
    input  wire logic       clk_sys,
    // link to the device
    output logic            csN,
    output logic            sck,
    output logic      [3:0] mOut,
    output logic      [3:0] mOe,
    input  wire logic [3:0] pins
);
    int lanes;
    // deselected at start, clock parked low
    initial begin
        csN   = 1'b1;
        sck   = 1'b0;
        mOut  = 4'h0;
        mOe   = 4'h1;
        lanes = 1;
    end
    // step just after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // change select with margin on both sides
    task automatic sel(input logic s);
        tick(20);
        csN = s;
        tick(20);
    endtask : sel
    // one byte, high chunk first; in dual and quad mode lanes released when drv is low, single lane keeps io0 driven
    task automatic xfer(input  logic [7:0] tx,
                        input  logic       drv,
                        output logic [7:0] rx);
        logic [7:0] sh;
        sh = tx;
        rx = 8'h00;
        for (int k = 0; k < 8 / lanes; k++) begin
            mOe = (lanes == 1) ? 4'h1 : !drv ? 4'h0 :
                  (lanes == 2) ? 4'h3 : 4'hF;
            mOut = (lanes == 4) ? sh[7:4] : (lanes == 2) ?
                   {2'b00, sh[7:6]} : {3'b000, sh[7]};
            sh = sh << lanes;
            tick(20);
            case (lanes)
                1:       rx = {rx[6:0], pins[1]};
                2:       rx = {rx[5:0], pins[1:0]};
                default: rx = {rx[3:0], pins};
            endcase
            sck = 1'b1;
            tick(20);
            sck = 1'b0;
        end
    endtask : xfer
endmodule : spi_master_model

// ==== sim/serial_sram_command_interface_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module serial_sram_command_interface_test;
    import sram_pkg::*;
    // ************************************************
    // clock, pins and counters
    // ************************************************
    logic       clk_sys    = 1'b0;
    logic       rst        = 1'b1;
    logic       csN;
    logic       sck;
    logic [3:0] mOut;
    logic [3:0] mOe;
    logic [3:0] ioOut;
    logic [3:0] ioOe;
    logic [3:0] pins;
    logic [3:0] floatQ     = 4'h0;
    logic [7:0] rx;
    int         n_errors   = 0;
    int         num_checks = 0;
    always #2 clk_sys = ~clk_sys;
    // lanes nobody drives show the inverse of their last level
    assign pins = (ioOe & ioOut) | (~ioOe & mOe & mOut) |
                  (~ioOe & ~mOe & floatQ);
    always @(posedge clk_sys) floatQ <= ~pins;
    spi_master_model u_mst (.clk_sys(clk_sys), .csN(csN), .sck(sck),
        .mOut(mOut), .mOe(mOe), .pins(pins));
    serial_sram_command_interface u_dut (.clk_sys(clk_sys), .rst(rst),
        .csN(csN), .sck(sck), .ioIn(pins), .ioOut(ioOut), .ioOe(ioOe));
    // ************************************************
    // frame helpers
    // ************************************************
    task automatic endF();
        u_mst.sel(1'b1);
        `CHK(ioOe, 4'h0)
    endtask : endF
    // one place lowers select, so every frame opens the same way
    task automatic startF();
        u_mst.sel(1'b0);
    endtask : startF
    task automatic op1(input logic [7:0] op);
        startF();
        u_mst.xfer(op, 1'b1, rx);
        endF();
    endtask : op1
    task automatic go(input logic [7:0] op, input logic [15:0] a);
        startF();
        u_mst.xfer(op, 1'b1, rx);
        u_mst.xfer(a[15:8], 1'b1, rx);
        u_mst.xfer(a[7:0], 1'b1, rx);
    endtask : go
    task automatic chkMode(input logic [7:0] e);
        startF();
        u_mst.xfer(MODE_REG_READ_CMD, 1'b1, rx);
        u_mst.xfer(8'h00, 1'b0, rx);
        `CHK(rx, e)
        endF();
    endtask : chkMode
    task automatic setMode(input logic [1:0] acc);
        startF();
        u_mst.xfer(MODE_REG_WRITE_CMD, 1'b1, rx);
        u_mst.xfer({acc, MODE_RSVD}, 1'b1, rx);
        endF();
        chkMode({acc, MODE_RSVD});
    endtask : setMode
    task automatic wr2(input logic [15:0] a, input logic [7:0] d0, d1);
        go(CMD_WRITE, a);
        u_mst.xfer(d0, 1'b1, rx);
        u_mst.xfer(d1, 1'b1, rx);
        endF();
    endtask : wr2
    task automatic rd2(input logic [15:0] a, input logic [7:0] e0, e1,
                       input logic [3:0] oeE);
        go(CMD_READ, a);
        u_mst.xfer(8'h00, 1'b0, rx);
        `CHK(rx, e0)
        u_mst.xfer(8'h00, 1'b0, rx);
        `CHK(rx, e1)
        `CHK(ioOe, oeE)
        endF();
    endtask : rd2
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_seq();
        chkMode(MODE_RESET);
        setMode(ACC_SEQ);
        wr2(16'hFFFF, 8'hA5, 8'h5A);
        rd2(16'hFFFF, 8'hA5, 8'h5A, 4'h2);
    endtask : t_seq
    task automatic t_page();
        setMode(ACC_PAGE);
        wr2(16'h013F, 8'h11, 8'h22);
        rd2(16'h013F, 8'h11, 8'h22, 4'h2);
    endtask : t_page
    task automatic t_byte();
        setMode(ACC_BYTE);
        wr2(16'h0200, 8'h77, 8'h88);
        go(CMD_READ, 16'h0200);
        u_mst.xfer(8'h00, 1'b0, rx);
        `CHK(rx, 8'h77)
        u_mst.tick(8);
        `CHK(ioOe, 4'h0)
        endF();
    endtask : t_byte
    task automatic t_lanes();
        op1(ENTER_DUAL_LANE_CMD);
        u_mst.lanes = 2;
        setMode(ACC_SEQ);
        rd2(16'hFFFF, 8'hA5, 8'h5A, 4'h3);
        op1(EXIT_MULTI_LANE_CMD);
        u_mst.lanes = 1;
        chkMode(8'h40);
        op1(ENTER_QUAD_LANE_CMD);
        u_mst.lanes = 4;
        rd2(16'hFFFF, 8'hA5, 8'h5A, 4'hF);
        op1(EXIT_MULTI_LANE_CMD);
        u_mst.lanes = 1;
        chkMode(8'h40);
    endtask : t_lanes
    // ************************************************
    // verdict, main sequence and watchdog
    // ************************************************
    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        u_mst.tick(4);
        rst = 1'b0;
        t_seq();
        t_page();
        t_byte();
        t_lanes();
        tally_and_finish();
    end
    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
endmodule : serial_sram_command_interface_test
